// ### pkg/dapm_pkg.sv
// Constants and types for the digital audio port mapper.
// Assumes one 40 MHz clock domain and sample-level stream ports.
package dapm_pkg;
	// ---------------------------------------------
	// Speed and rate codes
	// ---------------------------------------------
	typedef enum logic [1:0] {
		DAPM_SINGLE = 2'h0,
		DAPM_DOUBLE = 2'h1,
		DAPM_QUAD   = 2'h2
	} dapm_speed_e;
	localparam logic [1:0] RATE_32K  = 2'h0;
	localparam logic [1:0] RATE_441K = 2'h1;
	localparam logic [1:0] RATE_48K  = 2'h2;
	// ---------------------------------------------
	// Channel status layout
	// ---------------------------------------------
	localparam int CS_FRAMES     = 192;
	localparam int CS_BYTES      = 24;
	localparam int PRO_BIT       = 0;
	localparam int AUDIO_BIT     = 1;
	localparam int CON_COPY_BIT  = 2;
	localparam int CON_EMPH_LSB  = 3;
	localparam int CON_CAT_LSB   = 8;
	localparam int CON_FS_LSB    = 24;
	localparam int PRO_EMPH_LSB  = 2;
	localparam int PRO_FS_LSB    = 6;
	localparam int PRO_MODE_LSB  = 8;
	localparam int PRO_AUX_LSB   = 16;
	localparam int PRO_EFS_LSB   = 27;
	localparam logic [2:0] PRO_EMPH_NONE = 3'h4;
	localparam logic [3:0] PRO_MODE_TWO  = 4'h1;
	localparam logic [2:0] PRO_AUX_24    = 3'h1;
	localparam logic [3:0] PRO_LEN_24    = 4'hb;
	localparam logic [7:0] CON_CAT_GEN   = 8'h00;
	localparam logic [2:0] CON_EMPH_NONE = 3'h0;
	localparam int MIDI_HOLD_CYC = 4000;
	localparam int CNT_W         = 12;
	localparam logic [CNT_W-1:0] MIDI_HOLD = CNT_W'(MIDI_HOLD_CYC);
endpackage

// ### hw/dapm_cstat.sv
// Builds the outgoing channel status block and steps through it.
// Assumes one frame strobe per outgoing stereo frame.
`timescale 1ns/10ps
module dapm_cstat
	import dapm_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       consumer_in,
	input  wire logic [1:0] speed_in,
	input  wire logic [1:0] rate_in,
	input  wire logic       frame_in,
	output logic            cs_bit_out,
	output logic            block_start_out
);
	logic [7:0]   frame_idx;
	logic [191:0] block;

	function automatic logic [3:0] con_fs(input logic [1:0] spd, input logic [1:0] r);
		logic [3:0] f;
		f = 4'h0;
		unique case ({spd, r})
			4'h0: f = 4'h3;
			4'h1: f = 4'h0;
			4'h2: f = 4'h2;
			4'h4: f = 4'hb;
			4'h5: f = 4'h8;
			4'h6: f = 4'ha;
			4'h9: f = 4'hc;
			4'ha: f = 4'he;
			default: f = 4'h2;
		endcase
		return f;
	endfunction

	// ---------------------------------------------
	// Block contents
	// ---------------------------------------------
	always_comb begin
		block = '0;
		block[AUDIO_BIT] = 1'b0;
		if (consumer_in) begin
			block[PRO_BIT] = 1'b0;
			block[CON_COPY_BIT] = 1'b1;
			block[CON_EMPH_LSB +: 3] = CON_EMPH_NONE;
			block[CON_CAT_LSB +: 8] = CON_CAT_GEN;
			block[CON_FS_LSB +: 4] = con_fs(speed_in, rate_in);
		end else begin
			block[PRO_BIT] = 1'b1;
			block[PRO_EMPH_LSB +: 3] = PRO_EMPH_NONE;
			block[PRO_FS_LSB +: 2] = (rate_in == RATE_441K) ? 2'h1 :
				(rate_in == RATE_32K) ? 2'h3 : 2'h2;
			block[PRO_MODE_LSB +: 4] = PRO_MODE_TWO;
			block[PRO_AUX_LSB +: 3] = PRO_AUX_24;
			block[PRO_AUX_LSB + 3 +: 4] = PRO_LEN_24;
			block[PRO_EFS_LSB +: 4] = con_fs(speed_in, rate_in);
		end
	end

	// ---------------------------------------------
	// Frame stepping
	// ---------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			frame_idx <= 8'h00;
			cs_bit_out <= 1'b0;
			block_start_out <= 1'b0;
		end else if (frame_in) begin
			cs_bit_out <= block[frame_idx];
			block_start_out <= (frame_idx == 8'h00);
			frame_idx <= (frame_idx == 8'(CS_FRAMES - 1)) ? 8'h00 : frame_idx + 8'h01;
		end else begin
			block_start_out <= 1'b0;
		end
	end
endmodule

// ### hw/dapm_top.sv
// Channel mapper between host slots and optical and AES3 ports.
// Assumes slot strobes and samples come from logic on the same clock.
`timescale 1ns/10ps
module dapm_top
	import dapm_pkg::*;
(
	input  wire logic        MCLK_IN,
	input  wire logic        RSTN_IN,
	input  wire logic [1:0]  SPEED_IN,
	input  wire logic [1:0]  RATE_IN,
	input  wire logic        OPT2_AES_MODE_IN,
	input  wire logic        CONSUMER_IN,
	input  wire logic        OPT_IN_VALID_IN,
	input  wire logic        OPT_IN_PORT_IN,
	input  wire logic [2:0]  OPT_IN_SLOT_IN,
	input  wire logic [23:0] OPT_IN_DATA_IN,
	input  wire logic        AES_IN_VALID_IN,
	input  wire logic        AES_IN_RIGHT_IN,
	input  wire logic [23:0] AES_IN_DATA_IN,
	input  wire logic        AES_IN_CS_IN,
	input  wire logic        AES_IN_EMPH_IN,
	input  wire logic        PLAY_VALID_IN,
	input  wire logic [4:0]  PLAY_CH_IN,
	input  wire logic [23:0] PLAY_DATA_IN,
	input  wire logic        AES_FRAME_IN,
	input  wire logic [3:0]  MIDI_RX_IN,
	output logic             REC_VALID_OUT,
	output logic [4:0]       REC_CH_OUT,
	output logic [23:0]      REC_DATA_OUT,
	output logic             OPT_OUT_VALID_OUT,
	output logic             OPT_OUT_PORT_OUT,
	output logic [2:0]       OPT_OUT_SLOT_OUT,
	output logic [23:0]      OPT_OUT_DATA_OUT,
	output logic             OPT2_AES_FRAME_OUT,
	output logic             AES_OUT_VALID_OUT,
	output logic             AES_OUT_RIGHT_OUT,
	output logic [23:0]      AES_OUT_DATA_OUT,
	output logic             AES_OUT_CS_OUT,
	output logic             AES_OUT_BLOCK_OUT,
	output logic             AES_OUT_PRO_OUT,
	output logic [3:0]       MIDI_LED_OUT
);
	// Host channel numbers are zero based: 0..15 optical at single speed (0..7 double, 0..3 quad), 16/17 AES.
	localparam logic [4:0] AES_CH_L = 5'h10;
	localparam logic [4:0] AES_CH_R = 5'h11;

	logic [3:0]       midi_s1;
	logic [3:0]       midi_s2;
	logic [3:0]       midi_d;
	logic [CNT_W-1:0] midi_cnt [4];
	logic [3:0]       play_ps;

	// Slot of a port to host channel; split modes fold repeated samples.
	function automatic logic [4:0] slot_to_ch(input logic [1:0] spd, input logic port,
			input logic [2:0] slot);
		logic [4:0] c;
		c = 5'h00;
		unique case (spd)
			DAPM_DOUBLE: c = {2'b00, port, slot[2:1]};
			DAPM_QUAD:   c = {3'b000, port, slot[2]};
			default:     c = {1'b0, port, slot};
		endcase
		return c;
	endfunction

	// Host channel to port; one channel occupies 1, 2 or 4 slots.
	function automatic logic [3:0] ch_to_slot(input logic [1:0] spd, input logic [4:0] ch);
		logic [3:0] ps;
		ps = 4'h0;
		unique case (spd)
			DAPM_DOUBLE: ps = {ch[2], ch[1:0], 1'b0};
			DAPM_QUAD:   ps = {ch[1], ch[0], 2'b00};
			default:     ps = ch[3:0];
		endcase
		return ps;
	endfunction

	function automatic logic ch_ok(input logic [1:0] spd, input logic [4:0] ch);
		logic ok;
		ok = 1'b0;
		unique case (spd)
			DAPM_DOUBLE: ok = (ch < 5'h08);
			DAPM_QUAD:   ok = (ch < 5'h04);
			default:     ok = (ch < 5'h10);
		endcase
		return ok;
	endfunction

	function automatic logic is_aes_ch(input logic [4:0] ch);
		return (ch == AES_CH_L) || (ch == AES_CH_R);
	endfunction

	// ---------------------------------------------
	// Record path
	// ---------------------------------------------
	// Only the first slot of a split group is kept to avoid duplicates.
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			REC_VALID_OUT <= 1'b0;
			REC_CH_OUT <= 5'h00;
			REC_DATA_OUT <= 24'h00_0000;
		end else if (AES_IN_VALID_IN) begin
			REC_VALID_OUT <= 1'b1;
			REC_CH_OUT <= AES_IN_RIGHT_IN ? AES_CH_R : AES_CH_L;
			REC_DATA_OUT <= AES_IN_DATA_IN;
		end else if (OPT_IN_VALID_IN && !(OPT_IN_PORT_IN && OPT2_AES_MODE_IN)) begin
			REC_VALID_OUT <= (SPEED_IN == DAPM_SINGLE) ||
				(SPEED_IN == DAPM_DOUBLE && !OPT_IN_SLOT_IN[0]) ||
				(SPEED_IN == DAPM_QUAD && OPT_IN_SLOT_IN[1:0] == 2'b00);
			REC_CH_OUT <= slot_to_ch(SPEED_IN, OPT_IN_PORT_IN, OPT_IN_SLOT_IN);
			REC_DATA_OUT <= OPT_IN_DATA_IN;
		end else begin
			REC_VALID_OUT <= 1'b0;
		end
	end

	// ---------------------------------------------
	// Optical playback path
	// ---------------------------------------------
	// Split modes emit one slot per sample; the far end repeats the slot group.
	assign play_ps = ch_to_slot(SPEED_IN, PLAY_CH_IN);

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			OPT_OUT_VALID_OUT <= 1'b0;
			OPT_OUT_PORT_OUT <= 1'b0;
			OPT_OUT_SLOT_OUT <= 3'h0;
			OPT_OUT_DATA_OUT <= 24'h00_0000;
		end else if (PLAY_VALID_IN && ch_ok(SPEED_IN, PLAY_CH_IN)) begin
			OPT_OUT_VALID_OUT <= !(play_ps[3] && OPT2_AES_MODE_IN);
			OPT_OUT_PORT_OUT <= play_ps[3];
			OPT_OUT_SLOT_OUT <= play_ps[2:0];
			OPT_OUT_DATA_OUT <= PLAY_DATA_IN;
		end else begin
			OPT_OUT_VALID_OUT <= 1'b0;
		end
	end

	// ---------------------------------------------
	// AES playback path
	// ---------------------------------------------
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			AES_OUT_VALID_OUT <= 1'b0;
			AES_OUT_RIGHT_OUT <= 1'b0;
			AES_OUT_DATA_OUT <= 24'h00_0000;
			OPT2_AES_FRAME_OUT <= 1'b0;
			AES_OUT_PRO_OUT <= 1'b1;
		end else begin
			AES_OUT_PRO_OUT <= !CONSUMER_IN;
			AES_OUT_VALID_OUT <= PLAY_VALID_IN && is_aes_ch(PLAY_CH_IN);
			AES_OUT_RIGHT_OUT <= PLAY_CH_IN == AES_CH_R;
			AES_OUT_DATA_OUT <= PLAY_DATA_IN;
			OPT2_AES_FRAME_OUT <= OPT2_AES_MODE_IN && PLAY_VALID_IN &&
				is_aes_ch(PLAY_CH_IN);
		end
	end

	dapm_cstat u_cstat (
		.clk_in          (MCLK_IN),
		.rstn_in         (RSTN_IN),
		.consumer_in     (CONSUMER_IN),
		.speed_in        (SPEED_IN),
		.rate_in         (RATE_IN),
		.frame_in        (AES_FRAME_IN),
		.cs_bit_out      (AES_OUT_CS_OUT),
		.block_start_out (AES_OUT_BLOCK_OUT)
	);

	// ---------------------------------------------
	// MIDI activity
	// ---------------------------------------------
	// Any edge counts, so clock, timecode and sensing bytes all light it.
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			midi_s1 <= 4'hf;
			midi_s2 <= 4'hf;
			midi_d <= 4'hf;
		end else begin
			midi_s1 <= MIDI_RX_IN;
			midi_s2 <= midi_s1;
			midi_d <= midi_s2;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int i = 0; i < 4; i++) begin
				midi_cnt[i] <= '0;
			end
			MIDI_LED_OUT <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (midi_s2[i] != midi_d[i]) begin
					midi_cnt[i] <= MIDI_HOLD;
				end else if (midi_cnt[i] != '0) begin
					midi_cnt[i] <= midi_cnt[i] - CNT_W'(1);
				end
				MIDI_LED_OUT[i] <= (midi_s2[i] != midi_d[i]) || (midi_cnt[i] != '0);
			end
		end
	end
endmodule

// ### tb/dapm_far.sv
// Far-side model: frame pacing and MIDI senders.
// Assumes the bench clock; MIDI lines idle high.
`timescale 1ns/10ps
module dapm_far (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic go_in,
	output logic      frame_out,
	output logic [3:0] midi_out
);
	logic [1:0] cnt;
	// -----------------------------
	// Frame every 4 cycles, short
	// -----------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt <= 2'h0;
			frame_out <= 1'b0;
			midi_out <= 4'hf;
		end else begin
			cnt <= cnt + 2'h1;
			frame_out <= cnt == 2'h3;
			midi_out <= {4{!go_in}};
		end
	end
endmodule

// ### tb/dapm_top_properties.sv
// Port assertions for dapm_top.
// Assumes the bind below; one clock domain.
`timescale 1ns/10ps
module dapm_chk
	import dapm_pkg::*;
(
	input wire logic        MCLK_IN,
	input wire logic        RSTN_IN,
	input wire logic [1:0]  SPEED_IN,
	input wire logic        OPT2_AES_MODE_IN,
	input wire logic        CONSUMER_IN,
	input wire logic        OPT_IN_VALID_IN,
	input wire logic        AES_IN_VALID_IN,
	input wire logic        PLAY_VALID_IN,
	input wire logic [4:0]  PLAY_CH_IN,
	input wire logic [23:0] PLAY_DATA_IN,
	input wire logic        AES_FRAME_IN,
	input wire logic [3:0]  MIDI_RX_IN,
	input wire logic        REC_VALID_OUT,
	input wire logic        OPT_OUT_VALID_OUT,
	input wire logic        OPT_OUT_PORT_OUT,
	input wire logic [2:0]  OPT_OUT_SLOT_OUT,
	input wire logic        OPT2_AES_FRAME_OUT,
	input wire logic        AES_OUT_VALID_OUT,
	input wire logic [23:0] AES_OUT_DATA_OUT,
	input wire logic        AES_OUT_BLOCK_OUT,
	input wire logic        AES_OUT_PRO_OUT,
	input wire logic [3:0]  MIDI_LED_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	sequence midi_edge; $fell(MIDI_RX_IN[0]); endsequence
	sequence led_on; ##[1:5] MIDI_LED_OUT[0]; endsequence
	rec_cause_a: assert property (REC_VALID_OUT |-> $past(OPT_IN_VALID_IN || AES_IN_VALID_IN))
		else $error("record without input");
	opt_cause_a: assert property (OPT_OUT_VALID_OUT
		|-> $past(PLAY_VALID_IN) && $past(PLAY_CH_IN) < 16)
		else $error("optical out without play");
	opt2_off_a: assert property (OPT_OUT_VALID_OUT && $past(OPT2_AES_MODE_IN) |-> !OPT_OUT_PORT_OUT)
		else $error("second port sent in AES mode");
	dbl_slot_a: assert property (OPT_OUT_VALID_OUT && $past(SPEED_IN) == DAPM_DOUBLE
		|-> !OPT_OUT_SLOT_OUT[0]) else $error("odd slot at double");
	quad_slot_a: assert property (OPT_OUT_VALID_OUT && $past(SPEED_IN) == DAPM_QUAD
		|-> OPT_OUT_SLOT_OUT[1:0] == 2'h0) else $error("bad slot at quad");
	aes_mirror_a: assert property (PLAY_VALID_IN && PLAY_CH_IN == 5'h10 && OPT2_AES_MODE_IN
		|=> OPT2_AES_FRAME_OUT && AES_OUT_DATA_OUT == $past(PLAY_DATA_IN)) else $error("no mirror");
	fmt_sel_a: assert property ($past(RSTN_IN) && $stable(CONSUMER_IN)
		|-> AES_OUT_PRO_OUT == !CONSUMER_IN) else $error("status format wrong");
	blk_frame_a: assert property (AES_OUT_BLOCK_OUT |-> $past(AES_FRAME_IN) ##1 !AES_OUT_BLOCK_OUT)
		else $error("block mark misplaced");
	midi_led_a: assert property (midi_edge |-> led_on) else $error("MIDI led dark");
endmodule
bind dapm_top dapm_chk u_chk (.*);

// ### tb/tb_digital_audio_port_mapper.sv
// Self-checking bench for dapm_top.
// Assumes dapm_far as far side and the bound checker.
`timescale 1ns/10ps
module tb_digital_audio_port_mapper
	import dapm_pkg::*;
;
	logic MCLK_IN, RSTN_IN, OPT2_AES_MODE_IN, CONSUMER_IN, OPT_IN_VALID_IN, OPT_IN_PORT_IN;
	logic AES_IN_VALID_IN, AES_IN_RIGHT_IN, AES_IN_CS_IN, AES_IN_EMPH_IN, PLAY_VALID_IN;
	logic AES_FRAME_IN, REC_VALID_OUT, OPT_OUT_VALID_OUT, OPT_OUT_PORT_OUT, OPT2_AES_FRAME_OUT;
	logic AES_OUT_VALID_OUT, AES_OUT_RIGHT_OUT, AES_OUT_CS_OUT, AES_OUT_BLOCK_OUT, AES_OUT_PRO_OUT;
	logic [1:0]  SPEED_IN, RATE_IN;
	logic [2:0]  OPT_IN_SLOT_IN, OPT_OUT_SLOT_OUT;
	logic [3:0]  MIDI_RX_IN, MIDI_LED_OUT;
	logic [4:0]  PLAY_CH_IN, REC_CH_OUT;
	logic [23:0] OPT_IN_DATA_IN, AES_IN_DATA_IN, PLAY_DATA_IN, REC_DATA_OUT;
	logic [23:0] OPT_OUT_DATA_OUT, AES_OUT_DATA_OUT;
	logic [191:0] csb;
	logic go, fq;
	int fail_count, checks_done, idx, nb;
	dapm_top uut (.*);
	dapm_far far (.clk_in(MCLK_IN), .rstn_in(RSTN_IN), .go_in(go), .frame_out(AES_FRAME_IN),
		.midi_out(MIDI_RX_IN));
	initial begin
		MCLK_IN = 0;
		forever #12.5 MCLK_IN = ~MCLK_IN;
	end
	// -----------------------------
	// Status capture, bit 0 at mark
	// -----------------------------
	always @(posedge MCLK_IN) begin
		fq <= AES_FRAME_IN;
		if (AES_OUT_BLOCK_OUT === 1'b1) begin
			nb <= idx;
			idx <= 1;
			csb[0] <= AES_OUT_CS_OUT;
		end else if (fq === 1'b1 && idx < 192) begin
			csb[idx] <= AES_OUT_CS_OUT;
			idx <= idx + 1;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("mismatches=%0d checks=%0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic step;
		@(posedge MCLK_IN);
		OPT_IN_VALID_IN <= 0;
		AES_IN_VALID_IN <= 0;
		PLAY_VALID_IN <= 0;
		#1;
	endtask
	task automatic rec_map;
		for (int i = 0; i < 48; i++) begin
			SPEED_IN <= 2'(i / 16);
			OPT_IN_VALID_IN <= 1;
			OPT_IN_PORT_IN <= i[3];
			OPT_IN_SLOT_IN <= i[2:0];
			OPT_IN_DATA_IN <= 24'h00_1000 + 24'(i);
			step();
			chk(REC_VALID_OUT, (i % 16) % (1 << (i / 16)) == 0);
			if (REC_VALID_OUT === 1'b1) chk({REC_CH_OUT, REC_DATA_OUT},
				{5'((i % 16) >> (i / 16)), 24'h00_1000 + 24'(i)});
			@(posedge MCLK_IN);
		end
	endtask
	task automatic aes_in;
		SPEED_IN <= DAPM_SINGLE;
		OPT2_AES_MODE_IN <= 1;
		OPT_IN_VALID_IN <= 1;
		OPT_IN_PORT_IN <= 1;
		step();
		chk(REC_VALID_OUT, 0);
		@(posedge MCLK_IN);
		{AES_IN_VALID_IN, AES_IN_RIGHT_IN, AES_IN_CS_IN, AES_IN_EMPH_IN} <= 4'hf;
		AES_IN_DATA_IN <= 24'h12_3456;
		step();
		chk({REC_VALID_OUT, REC_CH_OUT, REC_DATA_OUT}, {1'b1, 5'h11, 24'h12_3456});
		@(posedge MCLK_IN);
	endtask
	task automatic play_map;
		logic v;
		for (int k = 0; k < 108; k++) begin
			automatic int m = k / 54;
			automatic int sp = (k / 18) % 3;
			automatic int c = k % 18;
			v = c < (16 >> sp) && !(m == 1 && c >= (8 >> sp));
			OPT2_AES_MODE_IN <= m[0];
			SPEED_IN <= 2'(sp);
			PLAY_VALID_IN <= 1;
			PLAY_CH_IN <= 5'(c);
			PLAY_DATA_IN <= 24'h00_2000 + 24'(c);
			step();
			chk(OPT_OUT_VALID_OUT, v);
			if (v) chk({OPT_OUT_PORT_OUT, OPT_OUT_SLOT_OUT, OPT_OUT_DATA_OUT},
				{c >= (8 >> sp), 3'((c % (8 >> sp)) << sp), 24'h00_2000 + 24'(c)});
			if (c > 15) chk({AES_OUT_VALID_OUT, AES_OUT_RIGHT_OUT, OPT2_AES_FRAME_OUT,
				AES_OUT_DATA_OUT}, {1'b1, c == 17, m[0], 24'h00_2000 + 24'(c)});
			else chk({AES_OUT_VALID_OUT, OPT2_AES_FRAME_OUT}, 2'h0);
			@(posedge MCLK_IN);
		end
	endtask
	task automatic wblk;
		int n;
		n = 0;
		@(posedge MCLK_IN);
		while (AES_OUT_BLOCK_OUT !== 1'b1 && n < 2000) begin
			@(posedge MCLK_IN);
			n++;
		end
		if (n == 2000) begin
			fail_count++;
			complete_run();
		end
	endtask
	task automatic cs_chk(input logic cons, input logic [1:0] spd, input logic [1:0] rate,
			input logic [3:0] fs);
		@(posedge MCLK_IN);
		CONSUMER_IN <= cons;
		SPEED_IN <= spd;
		RATE_IN <= rate;
		wblk();
		wblk();
		#1 chk({nb[9:0], csb[PRO_BIT], csb[AUDIO_BIT]}, {10'(CS_FRAMES), !cons, 1'b0});
		chk(AES_OUT_PRO_OUT, !cons);
		if (cons) chk({csb[CON_COPY_BIT], csb[CON_CAT_LSB +: 8], csb[CON_EMPH_LSB +: 3],
			csb[CON_FS_LSB +: 4]}, {1'b1, CON_CAT_GEN, CON_EMPH_NONE, fs});
		else chk({csb[PRO_EMPH_LSB +: 3], csb[PRO_MODE_LSB +: 4], csb[PRO_AUX_LSB +: 3],
			csb[PRO_AUX_LSB + 3 +: 4], csb[PRO_EFS_LSB +: 4]},
			{PRO_EMPH_NONE, PRO_MODE_TWO, PRO_AUX_24, PRO_LEN_24, fs});
	endtask
	task automatic midi;
		@(posedge MCLK_IN);
		go <= 1;
		@(posedge MCLK_IN);
		go <= 0;
		repeat (8) @(posedge MCLK_IN);
		#1 chk(MIDI_LED_OUT, 4'hf);
		repeat (MIDI_HOLD_CYC + 20) @(posedge MCLK_IN);
		#1 chk(MIDI_LED_OUT, 4'h0);
	endtask
	initial begin
		{RSTN_IN, OPT2_AES_MODE_IN, CONSUMER_IN, OPT_IN_VALID_IN, OPT_IN_PORT_IN, go} = 0;
		{AES_IN_VALID_IN, AES_IN_RIGHT_IN, AES_IN_CS_IN, AES_IN_EMPH_IN, PLAY_VALID_IN} = 0;
		{SPEED_IN, RATE_IN, OPT_IN_SLOT_IN, PLAY_CH_IN} = 0;
		{OPT_IN_DATA_IN, AES_IN_DATA_IN, PLAY_DATA_IN} = 0;
		repeat (8) @(posedge MCLK_IN);
		RSTN_IN <= 1;
		@(posedge MCLK_IN);
		rec_map();
		aes_in();
		play_map();
		cs_chk(0, DAPM_SINGLE, RATE_48K, 4'h2);
		cs_chk(1, DAPM_SINGLE, RATE_48K, 4'h2);
		cs_chk(1, DAPM_DOUBLE, RATE_441K, 4'h8);
		cs_chk(0, DAPM_QUAD, RATE_48K, 4'he);
		cs_chk(1, DAPM_SINGLE, RATE_32K, 4'h3);
		midi();
		complete_run();
	end
endmodule
